//--- logic/rtcc_pkg.sv
// Constants, types and register layout of the RTC clock and control section.
// Assumes a byte-wide register port and one 100 MHz system clock.

package rtcc_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [19:0] ADDR_TICK_SEL = 20'hF02D8;
  localparam logic [19:0] ADDR_CTRL_A   = 20'hFFF9D;
  localparam logic [19:0] ADDR_CTRL_B   = 20'hFFF9E;
  localparam logic [7:0]  RST_TICK_SEL  = 8'h00;
  localparam logic [7:0]  RST_CTRL_A    = 8'h00;
  localparam logic [7:0]  RST_CTRL_B    = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TS_SRC     = 7;
  localparam int TS_PSA_LSB = 5;
  localparam int TS_PSB_LSB = 0;
  localparam int CA_RUN     = 7;
  localparam int CA_OHZ     = 5;
  localparam int CA_FMT     = 3;
  localparam int CA_PSEL    = 0;
  localparam int CB_AME     = 7;
  localparam int CB_AIE     = 6;
  localparam int CB_AFLG    = 4;
  localparam int CB_PFLG    = 3;
  localparam int CB_HST     = 1;
  localparam int CB_HRQ     = 0;

  // ----------------------------------------------------------------
  // Divisors and timing
  // ----------------------------------------------------------------
  localparam logic [8:0] DIV_A_122 = 9'h07A;
  localparam logic [8:0] DIV_A_305 = 9'h131;
  localparam logic [8:0] DIV_A_183 = 9'h0B7;
  localparam int SUBSEC_TICKS_DEF  = 32768;  // Ticks per second

  typedef enum logic [2:0] {
    PSEL_OFF    = 3'b000,
    PSEL_HALF   = 3'b001,
    PSEL_SEC    = 3'b010,
    PSEL_MIN    = 3'b011,
    PSEL_HOUR   = 3'b100,
    PSEL_DAY    = 3'b101,
    PSEL_MONTH  = 3'b110,
    PSEL_MONTH1 = 3'b111
  } rtcc_psel_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [19:0] addr;
    logic [7:0]  wdata;
  } rtcc_sfr_req_t;

  typedef struct packed {
    logic sec_carry;    // Next seconds step rolls 59 to 00
    logic min_carry;    // Next seconds step also rolls the minute
    logic hour_carry;   // ... and the hour into a new day
    logic month_carry;  // ... and the day into a new month
    logic alarm_match;  // Alarm comparator equal
    logic sec_write;    // Seconds register written
  } rtcc_cal_t;

endpackage

//--- logic/rtcc_presc.sv
// Two-stage tick prescaler producing the RTC operating clock enable.
// Assumes both source clocks arrive as one-cycle enables on the system clock.
`timescale 1ns/100ps

module rtcc_presc (
  input  wire logic       clock,        // System clock
  input  wire logic       rst_n,        // Synchronised reset
  input  wire logic [7:0] tick_sel,     // Tick select register
  input  wire logic       src_mx_tick,  // System clock source enable
  input  wire logic       src_ho_tick,  // On-chip oscillator enable
  output logic            rtc_tick      // Operating clock enable
);

  typedef struct packed {
    logic [8:0] cnt_a;
    logic [2:0] cnt_b;
    logic       tick;
  } rtcc_presc_st_t;

  rtcc_presc_st_t st_r;
  rtcc_presc_st_t st_nxt;

  always_comb begin
    logic       src;
    logic [8:0] lim;
    logic [2:0] mask;
    logic       a_out;
    st_nxt = st_r;
    src    = tick_sel[rtcc_pkg::TS_SRC] ? src_ho_tick : src_mx_tick;
    lim    = rtcc_pkg::DIV_A_122;
    mask   = 3'h0;
    a_out  = 1'b0;
    unique case (tick_sel[rtcc_pkg::TS_PSA_LSB +: 2])
      2'h0: lim = rtcc_pkg::DIV_A_122;
      2'h1: lim = rtcc_pkg::DIV_A_305;
      2'h2: lim = rtcc_pkg::DIV_A_183;
      2'h3: lim = 9'h000;
    endcase
    unique case (tick_sel[rtcc_pkg::TS_PSB_LSB +: 2])
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
    endcase
    st_nxt.tick = 1'b0;
    // Prohibited setting holds the divider still: no ticks at all
    if (lim == 9'h000) begin
      st_nxt.cnt_a = 9'h000;
    end else if (src) begin
      // Also catches a count left above a newly lowered limit
      if (st_r.cnt_a >= lim - 9'h001) begin
        st_nxt.cnt_a = 9'h000;
        a_out        = 1'b1;
      end else begin
        st_nxt.cnt_a = st_r.cnt_a + 9'h001;
      end
    end
    if (a_out) begin
      st_nxt.cnt_b = st_r.cnt_b + 3'h1;
      st_nxt.tick  = ((st_r.cnt_b & mask) == mask);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rtc_tick = st_r.tick;

endmodule

//--- logic/rtcc_subsec.sv
// Sub-second counter with hold handling for the seconds step.
// Assumes tick is the RTC operating clock enable.
`timescale 1ns/100ps

module rtcc_subsec #(
  parameter int TICKS = rtcc_pkg::SUBSEC_TICKS_DEF
) (
  input  wire logic clock,      // System clock
  input  wire logic rst_n,      // Synchronised reset
  input  wire logic tick,       // Operating clock enable
  input  wire logic run,        // Counter run
  input  wire logic hold,       // Hold request
  input  wire logic sec_write,  // Seconds register written
  output logic      sec_inc,    // Seconds step pulse
  output logic      half_evt,   // Mid-second pulse
  output logic      first_half  // Level, first half of second
);

  localparam logic [15:0] LAST = 16'(TICKS - 1);
  localparam logic [15:0] HALF = 16'(TICKS / 2 - 1);

  typedef struct packed {
    logic [15:0] cnt;
    logic        pend;
    logic        inc;
    logic        half;
    logic        first;
  } rtcc_sub_st_t;

  rtcc_sub_st_t st_r;
  rtcc_sub_st_t st_nxt;

  always_comb begin
    logic ovf;
    st_nxt      = st_r;
    st_nxt.inc  = 1'b0;
    st_nxt.half = 1'b0;
    ovf         = 1'b0;
    if (run && tick) begin
      // Keeps running through hold
      if (st_r.cnt == LAST) begin
        st_nxt.cnt = 16'h0000;
        ovf        = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 16'h0001;
      end
      st_nxt.half = (st_r.cnt == HALF);
    end
    if (ovf && hold) begin
      st_nxt.pend = 1'b1;
    end else if (ovf || (st_r.pend && !hold)) begin
      st_nxt.inc  = 1'b1;
      st_nxt.pend = 1'b0;
    end
    if (sec_write) begin
      st_nxt.cnt  = 16'h0000;
      st_nxt.pend = 1'b0;
      st_nxt.inc  = 1'b0;
      st_nxt.half = 1'b0;
    end
    st_nxt.first = (st_nxt.cnt <= HALF);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sec_inc    = st_r.inc;
  assign half_evt   = st_r.half;
  assign first_half = st_r.first;

endmodule

//--- logic/rtcc_top.sv
// Clock and control section of the calendar RTC: registers, flags, 1 Hz pin.
// Assumes the calendar counters sit outside and report carries and alarm match.
`timescale 1ns/100ps

module rtcc_top #(
  parameter int SUBSEC_TICKS = rtcc_pkg::SUBSEC_TICKS_DEF
) (
  input  wire logic                    clock,           // 100 MHz system clock
  input  wire logic                    rstn,            // Async reset, active low
  input  wire rtcc_pkg::rtcc_sfr_req_t sfr_req,         // Register access request
  output logic [7:0]                   sfr_rdata,       // Read data, next cycle
  input  wire logic                    src_mx_tick,     // System clock source enable
  input  wire logic                    src_ho_tick,     // Oscillator source enable
  input  wire rtcc_pkg::rtcc_cal_t     cal,             // Calendar status
  output logic                         sec_inc,         // Advance seconds counter
  output logic                         cal_frozen,      // Calendar held
  output logic                         hour_format_24,  // Hour format level
  output logic                         hour_fmt_conv,   // Convert hour pulse
  output logic                         one_hz_pin,      // 1 Hz output
  output logic                         rtc_irq          // Shared interrupt pulse
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           tick_sel;
    logic                 run;
    logic                 ohz_en;
    logic                 fmt24;
    rtcc_pkg::rtcc_psel_t psel;
    logic                 ame;
    logic                 aie;
    logic                 aflag;
    logic                 pflag;
    logic                 hold_st;
    logic                 hold_rq;
    logic                 match_d;
    logic                 match_seen;
    logic [7:0]           rdata;
    logic                 irq;
    logic                 ohz;
    logic                 conv;
  } rtcc_top_st_t;

  rtcc_top_st_t st_r;
  rtcc_top_st_t st_nxt;

  logic tick;
  logic sec_step;
  logic half_evt;
  logic first_half;

  // ----------------------------------------------------------------
  // Tick generation and sub-second counter
  // ----------------------------------------------------------------
  rtcc_presc u_presc (
    .clock       (clock),
    .rst_n       (rst_n),
    .tick_sel    (st_r.tick_sel),
    .src_mx_tick (src_mx_tick),
    .src_ho_tick (src_ho_tick),
    .rtc_tick    (tick)
  );

  rtcc_subsec #(
    .TICKS (SUBSEC_TICKS)
  ) u_subsec (
    .clock      (clock),
    .rst_n      (rst_n),
    .tick       (tick),
    .run        (st_r.run),
    .hold       (st_r.hold_rq),
    .sec_write  (cal.sec_write),
    .sec_inc    (sec_step),
    .half_evt   (half_evt),
    .first_half (first_half)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_a;
    logic wr_b;
    logic per_evt;
    logic alarm_set;
    logic [7:0] ra;
    logic [7:0] rb;
    st_nxt    = st_r;
    wr_a      = sfr_req.wr && (sfr_req.addr == rtcc_pkg::ADDR_CTRL_A);
    wr_b      = sfr_req.wr && (sfr_req.addr == rtcc_pkg::ADDR_CTRL_B);
    per_evt   = 1'b0;
    alarm_set = 1'b0;

    // Periodic event selection
    unique case (st_r.psel)
      rtcc_pkg::PSEL_OFF:    per_evt = 1'b0;
      rtcc_pkg::PSEL_HALF:   per_evt = sec_step || half_evt;
      rtcc_pkg::PSEL_SEC:    per_evt = sec_step;
      rtcc_pkg::PSEL_MIN:    per_evt = sec_step && cal.sec_carry;
      rtcc_pkg::PSEL_HOUR:   per_evt = sec_step && cal.min_carry;
      rtcc_pkg::PSEL_DAY:    per_evt = sec_step && cal.hour_carry;
      rtcc_pkg::PSEL_MONTH,
      rtcc_pkg::PSEL_MONTH1: per_evt = sec_step && cal.month_carry;
    endcase

    // Alarm: match edge seen on one tick, flag on the next
    if (tick) begin
      st_nxt.match_d    = cal.alarm_match;
      st_nxt.match_seen = st_r.ame && cal.alarm_match && !st_r.match_d;
      alarm_set         = st_r.match_seen && st_r.ame;
      st_nxt.hold_st    = st_r.hold_rq;
    end

    // Register writes
    if (sfr_req.wr && (sfr_req.addr == rtcc_pkg::ADDR_TICK_SEL)) begin
      st_nxt.tick_sel = sfr_req.wdata & 8'hE3;
    end
    st_nxt.conv = 1'b0;
    if (wr_a) begin
      st_nxt.run    = sfr_req.wdata[rtcc_pkg::CA_RUN];
      st_nxt.ohz_en = sfr_req.wdata[rtcc_pkg::CA_OHZ];
      st_nxt.fmt24  = sfr_req.wdata[rtcc_pkg::CA_FMT];
      st_nxt.psel   = rtcc_pkg::rtcc_psel_t'(sfr_req.wdata[rtcc_pkg::CA_PSEL +: 3]);
      st_nxt.conv   = (sfr_req.wdata[rtcc_pkg::CA_FMT] != st_r.fmt24);
    end
    if (wr_b) begin
      st_nxt.ame     = sfr_req.wdata[rtcc_pkg::CB_AME];
      st_nxt.aie     = sfr_req.wdata[rtcc_pkg::CB_AIE];
      st_nxt.hold_rq = sfr_req.wdata[rtcc_pkg::CB_HRQ];
      // Zero clears, one leaves the flag alone
      st_nxt.aflag   = st_r.aflag && sfr_req.wdata[rtcc_pkg::CB_AFLG];
      st_nxt.pflag   = st_r.pflag && sfr_req.wdata[rtcc_pkg::CB_PFLG];
    end
    // Set beats a clear in the same cycle
    if (alarm_set) begin
      st_nxt.aflag = 1'b1;
    end
    if (per_evt) begin
      st_nxt.pflag = 1'b1;
    end
    st_nxt.irq = per_evt || (alarm_set && st_r.aie);

    // 1 Hz: high in first half of each second, only while running
    st_nxt.ohz = st_r.run && st_r.ohz_en && first_half;

    // Read data, registered
    ra = 8'h00;
    ra[rtcc_pkg::CA_RUN]        = st_r.run;
    ra[rtcc_pkg::CA_OHZ]        = st_r.ohz_en;
    ra[rtcc_pkg::CA_FMT]        = st_r.fmt24;
    ra[rtcc_pkg::CA_PSEL +: 3]  = st_r.psel;
    rb = 8'h00;
    rb[rtcc_pkg::CB_AME]  = st_r.ame;
    rb[rtcc_pkg::CB_AIE]  = st_r.aie;
    rb[rtcc_pkg::CB_AFLG] = st_r.aflag;
    rb[rtcc_pkg::CB_PFLG] = st_r.pflag;
    rb[rtcc_pkg::CB_HST]  = st_r.hold_st;
    rb[rtcc_pkg::CB_HRQ]  = st_r.hold_rq;
    if (sfr_req.rd) begin
      unique case (sfr_req.addr)
        rtcc_pkg::ADDR_TICK_SEL: st_nxt.rdata = st_r.tick_sel;
        rtcc_pkg::ADDR_CTRL_A:   st_nxt.rdata = ra;
        rtcc_pkg::ADDR_CTRL_B:   st_nxt.rdata = rb;
        default:                 st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.tick_sel <= rtcc_pkg::RST_TICK_SEL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Seconds step reaches the calendar only outside hold
  assign sec_inc        = sec_step;
  assign cal_frozen     = st_r.hold_st;
  assign hour_format_24 = st_r.fmt24;
  assign hour_fmt_conv  = st_r.conv;
  assign one_hz_pin     = st_r.ohz;
  assign rtc_irq        = st_r.irq;
  assign sfr_rdata      = st_r.rdata;

endmodule

//--- testbench/rtcc_top_properties.sv
// Port-level assertions for the RTC clock and control section.
// Assumes register writes take effect on the edge where wr is sampled high.
`timescale 1ns/100ps

module rtcc_top_properties #(
  parameter int SUBSEC_TICKS = 8
) (
  input wire logic                    clock,           // System clock
  input wire logic                    rstn,            // Async reset, active low
  input wire rtcc_pkg::rtcc_sfr_req_t sfr_req,         // Register request
  input wire logic [7:0]              sfr_rdata,       // Read data
  input wire logic                    src_mx_tick,     // System source enable
  input wire logic                    src_ho_tick,     // Oscillator source enable
  input wire rtcc_pkg::rtcc_cal_t     cal,             // Calendar status
  input wire logic                    sec_inc,         // Seconds step
  input wire logic                    cal_frozen,      // Hold status
  input wire logic                    hour_format_24,  // Format level
  input wire logic                    hour_fmt_conv,   // Convert pulse
  input wire logic                    one_hz_pin,      // 1 Hz pin
  input wire logic                    rtc_irq          // Shared interrupt
);
  // ------------------------------------------------------------
  // Shadow of written control bits
  // ------------------------------------------------------------
  logic [7:0] ts_r;
  logic [7:0] ca_r;
  logic [7:0] cb_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ts_r <= 8'h00;
      ca_r <= 8'h00;
      cb_r <= 8'h00;
    end else if (sfr_req.wr) begin
      if (sfr_req.addr == rtcc_pkg::ADDR_TICK_SEL) ts_r <= sfr_req.wdata;
      if (sfr_req.addr == rtcc_pkg::ADDR_CTRL_A) ca_r <= sfr_req.wdata;
      if (sfr_req.addr == rtcc_pkg::ADDR_CTRL_B) cb_r <= sfr_req.wdata;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking dck @(posedge clock); endclocking
  default disable iff (!rstn);

  one_hz_gate_a: assert property (
    !(ca_r[7] && ca_r[5]) && !$past(ca_r[7] && ca_r[5]) |-> !one_hz_pin)
    else $error("one hz pin active while gated off");
  run_stop_a: assert property (
    !ca_r[7] && !$past(ca_r[7]) |-> !sec_inc) else $error("seconds step while stopped");
  hold_freeze_a: assert property (
    cb_r[0] && $past(cb_r[0]) |-> !sec_inc) else $error("seconds step during hold");
  hold_status_a: assert property (
    $rose(cb_r[0]) && ts_r == 8'h00 |-> ##[1:300] cal_frozen)
    else $error("hold status late");
  fmt_level_a: assert property (
    $stable(ca_r[3]) |-> hour_format_24 == ca_r[3]) else $error("format level wrong");
  fmt_conv_a: assert property (
    $changed(ca_r[3]) |-> ##[0:2] hour_fmt_conv) else $error("no hour conversion pulse");
  irq_quiet_a: assert property (
    ca_r[2:0] == 3'b000 && !cb_r[6] && $past(ca_r[2:0] == 3'b000 && !cb_r[6]) |-> !rtc_irq)
    else $error("interrupt with all sources off");
  sec_irq_a: assert property (
    sec_inc && ca_r[2:0] == 3'b010 |-> ##[0:1] rtc_irq) else $error("no per-second interrupt");
  alarm_irq_a: assert property (
    $rose(cal.alarm_match) && cb_r[7] && cb_r[6] && ts_r == 8'h00 |-> ##[1:300] rtc_irq)
    else $error("no alarm interrupt");

  cover property (sec_inc && ca_r[2:0] == 3'b001);
  cover property ($rose(cal_frozen));
  cover property (rtc_irq && cb_r[6]);
  cover property (one_hz_pin);
endmodule

bind rtcc_top rtcc_top_properties #(.SUBSEC_TICKS(SUBSEC_TICKS)) u_props (
  .clock(clock), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .src_mx_tick(src_mx_tick), .src_ho_tick(src_ho_tick), .cal(cal), .sec_inc(sec_inc),
  .cal_frozen(cal_frozen), .hour_format_24(hour_format_24),
  .hour_fmt_conv(hour_fmt_conv), .one_hz_pin(one_hz_pin), .rtc_irq(rtc_irq));

//--- testbench/test_rtcc_top.sv
// Self-checking bench for the RTC clock and control section.
// Assumes source enables held high, so a tick lasts div_a*div_b clock cycles.
`timescale 1ns/100ps

module test_rtcc_top;
  localparam int TK = 8;
  localparam logic [19:0] A_TS = rtcc_pkg::ADDR_TICK_SEL;
  localparam logic [19:0] A_A  = rtcc_pkg::ADDR_CTRL_A;
  localparam logic [19:0] A_B  = rtcc_pkg::ADDR_CTRL_B;

  logic                    clock = 1'b0;
  logic                    rstn = 1'b0;
  rtcc_pkg::rtcc_sfr_req_t sfr_req = '0;
  logic [7:0]              sfr_rdata;
  logic                    src_mx_tick = 1'b1;
  logic                    src_ho_tick = 1'b0;
  rtcc_pkg::rtcc_cal_t     cal = '0;
  logic                    sec_inc, cal_frozen, hour_format_24, hour_fmt_conv;
  logic                    one_hz_pin, rtc_irq;
  int                      fails = 0;
  int                      cmp_count = 0;
  int                      cyc = 0;
  int                      last_inc = 0;
  int                      n, n_inc, n_irq;
  logic [31:0]             lfsr_r = 32'h1EF782A3;
  logic [7:0]              rd_q[$];
  int                      per_q[$];
  logic                    rd_pend = 1'b0;
  logic [7:0]              ts_v[6] = '{8'h00, 8'h20, 8'h40, 8'h01, 8'h02, 8'h03};
  int                      dv_v[6] = '{122, 305, 183, 244, 488, 976};
  logic [3:0]              pv[13] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF,
                                      4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  int                      pe[13] = '{0, 2, 1, 1, 1, 1, 1, 1, 0, 0, 0, 0, 0};

  always #5 clock = ~clock;

  rtcc_top #(.SUBSEC_TICKS(TK)) uut (
    .clock(clock), .rstn(rstn), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .src_mx_tick(src_mx_tick), .src_ho_tick(src_ho_tick), .cal(cal), .sec_inc(sec_inc),
    .cal_frozen(cal_frozen), .hour_format_24(hour_format_24),
    .hour_fmt_conv(hour_fmt_conv), .one_hz_pin(one_hz_pin), .rtc_irq(rtc_irq));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    sfr_req.wr <= 1'b0;
  endtask

  // Expected byte is queued; the monitor compares it a cycle later
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(posedge clock);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    rd_q.push_back(e);
    @(posedge clock);
    sfr_req.rd <= 1'b0;
  endtask

  task automatic wait_inc(input int lim);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (sec_inc !== 1'b1 && n < lim);
  endtask

  task automatic quiet(input int len);
    n_inc = 0;
    n_irq = 0;
    repeat (len) begin
      @(posedge clock);
      n_inc += (sec_inc === 1'b1);
      n_irq += (rtc_irq === 1'b1);
    end
  endtask

  task automatic period(input logic [7:0] ts, input int exp);
    wr(A_TS, ts);
    // Let the first divider output under the new setting pass
    quiet(320);
    wait_inc(20000);
    per_q.push_back(exp);
    wait_inc(20000);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Monitor: read data and seconds-step spacing
  // ------------------------------------------------------------
  always @(posedge clock) cyc <= cyc + 1;

  always @(negedge clock) begin
    if (rd_pend && rd_q.size() > 0) check(sfr_rdata, rd_q.pop_front(), "rdata");
    rd_pend = sfr_req.rd;
    if (sec_inc === 1'b1) begin
      if (per_q.size() > 0) check(cyc - last_inc, per_q.pop_front(), "period");
      last_inc = cyc;
    end
  end

  initial begin
    #980000;
    fails++;
    finish_test();
  end

  initial begin
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(A_TS, 8'h00);
    rd(A_A, 8'h00);
    rd(A_B, 8'h00);
    rd(20'hFFF9F, 8'h00);
    // Reserved tick-select bits always read back zero
    repeat (4) begin
      lfsr_r = lfsr(lfsr_r);
      wr(A_TS, lfsr_r[7:0]);
      rd(A_TS, lfsr_r[7:0] & 8'hE3);
    end
    wr(A_A, 8'h80);
    foreach (ts_v[i]) period(ts_v[i], dv_v[i] * TK);
    src_mx_tick <= 1'b0;
    src_ho_tick <= 1'b1;
    period(8'h80, 122 * TK);
    src_ho_tick <= 1'b0;
    src_mx_tick <= 1'b1;
    quiet(3000);
    check(n_inc, 0, "ho source idle");
    wr(A_TS, 8'h60);
    quiet(3000);
    check(n_inc, 0, "prohibited divisor");
    wr(A_TS, 8'h00);
    foreach (pv[i]) begin
      cal <= {{4{pv[i][3]}}, 2'b00};
      wr(A_A, {5'b10000, pv[i][2:0]});
      wait_inc(3000);
      quiet(1);
      n = n_irq;
      while (sec_inc !== 1'b1) begin
        @(posedge clock);
        n += (rtc_irq === 1'b1);
      end
      check(n, pe[i], "periodic count");
    end
    wr(A_A, 8'h82);
    wait_inc(3000);
    rd(A_B, 8'h08);
    wr(A_B, 8'h08);
    rd(A_B, 8'h08);
    wr(A_B, 8'h00);
    rd(A_B, 8'h00);
    wr(A_A, 8'h80);
    wr(A_B, 8'h01);
    n = 0;
    while (cal_frozen !== 1'b1 && n < 130) begin
      @(posedge clock);
      n++;
    end
    check(cal_frozen, 1'b1, "hold status");
    rd(A_B, 8'h03);
    quiet(1500);
    check(n_inc, 0, "frozen steps");
    wr(A_B, 8'h00);
    quiet(4);
    check(n_inc, 1, "kept overflow");
    wr(A_B, 8'h01);
    quiet(1500);
    cal.sec_write <= 1'b1;
    @(posedge clock);
    cal.sec_write <= 1'b0;
    wr(A_B, 8'h00);
    quiet(4);
    check(n_inc, 0, "dropped overflow");
    wr(A_B, 8'h01);
    wr(A_A, 8'h88);
    @(negedge clock);
    check(hour_fmt_conv, 1'b1, "format convert");
    rd(A_A, 8'h88);
    check(hour_format_24, 1'b1, "format level");
    wr(A_A, 8'h00);
    wr(A_B, 8'h00);
    wr(A_A, 8'h20);
    quiet(1500);
    check(n_inc, 0, "stopped steps");
    check(one_hz_pin, 1'b0, "pin while stopped");
    wr(A_A, 8'hA0);
    wait_inc(3000);
    quiet(20);
    check(one_hz_pin, 1'b1, "pin first half");
    quiet(680);
    check(one_hz_pin, 1'b0, "pin second half");
    wr(A_B, 8'h40);
    cal.alarm_match <= 1'b1;
    quiet(400);
    rd(A_B, 8'h40);
    cal.alarm_match <= 1'b0;
    // A tick must see the match low, or no new edge is detected
    quiet(300);
    wr(A_B, 8'hC0);
    cal.alarm_match <= 1'b1;
    n = 0;
    while (rtc_irq !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    check(rtc_irq, 1'b1, "alarm irq");
    rd(A_B, 8'hD0);
    cal.alarm_match <= 1'b0;
    wr(A_B, 8'h80);
    rd(A_B, 8'h80);
    quiet(300);
    cal.alarm_match <= 1'b1;
    quiet(400);
    check(n_irq, 0, "masked alarm irq");
    rd(A_B, 8'h90);
    repeat (3) @(posedge clock);
    finish_test();
  end
endmodule
